// ==== verilog/bss_slave.sv ====
`timescale 1ns/1ps
module bss_slave (
    input  wire logic                            clk_i,
    input  wire logic                            rstn_i,
    // link pins
    input  wire logic                            serial_clock_i,
    input  wire logic                            slave_chip_select_n_i,
    input  wire logic                            slave_in_line_i,
    output logic                                 slave_out_line_o,
    output logic                                 slave_out_line_oe_o,
    output logic                                 slave_enable_handshake_n_o,
    // control bits
    input  wire logic                            module_enable_i,
    input  wire logic                            dma_request_enable_i,
    input  wire logic                            force_length_error_i,
    input  wire logic                            multi_buffer_mode_i,
    input  wire logic                            four_pin_mode_i,
    input  wire logic                            group_start_i,
    input  wire logic [bss_pkg::IDX_W-1:0]       group_first_i,
    // transmit ram write
    input  wire logic                            tx_write_i,
    input  wire logic [bss_pkg::IDX_W-1:0]       tx_index_i,
    input  wire logic [bss_pkg::WORD_W-1:0]      tx_data_i,
    input  wire logic [2:0]                      buffer_mode_field_i,
    input  wire logic                            chip_select_hold_i,
    // receive ram read
    input  wire logic                            rx_read_i,
    input  wire logic [bss_pkg::IDX_W-1:0]       rx_index_i,
    output logic [bss_pkg::WORD_W-1:0]           rx_data_o,
    output logic                                 receive_empty_flag_o,
    // status
    output logic                                 rx_dma_request_o,
    output logic                                 data_length_error_o,
    output logic                                 overrun_error_o,
    output logic                                 suspended_o,
    output logic                                 busy_o
);
    localparam logic [bss_pkg::CNT_W-1:0] LAST_BIT = 5'(bss_pkg::WORD_W - 1);

    logic [bss_pkg::WORD_W-1:0] tx_ram [bss_pkg::BUF_N];
    logic [bss_pkg::WORD_W-1:0] rx_ram [bss_pkg::BUF_N];
    logic [2:0]                 mode_ram [bss_pkg::BUF_N];
    logic [bss_pkg::BUF_N-1:0]  transmit_full_flag_reg;
    logic [bss_pkg::BUF_N-1:0]  receive_empty_flag_reg;
    bss_pkg::bss_state_t        state_reg;
    logic [bss_pkg::IDX_W-1:0]  cur_reg;
    logic [bss_pkg::WORD_W-1:0] shift_out_reg;
    logic [bss_pkg::WORD_W-1:0] shift_in_reg;
    logic [bss_pkg::CNT_W-1:0]  bit_cnt_reg;
    logic [2:0]                 sclk_sync_reg;
    logic [1:0]                 cs_sync_reg;
    logic [1:0]                 si_sync_reg;
    logic                       word_done;
    logic                       sclk_rise;
    logic                       sclk_fall;
    logic                       cs_active;
    logic                       suspend_hit;

    // ==========================================
    // synchronisers: edges are taken from settled samples at bus clock rather than the raw
    // clock pin, so the serial clock must run well below the bus clock rate
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sclk_sync_reg <= 3'h0;
            cs_sync_reg   <= 2'h3;
            si_sync_reg   <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clock_i};
            cs_sync_reg   <= {cs_sync_reg[0], slave_chip_select_n_i};
            si_sync_reg   <= {si_sync_reg[0], slave_in_line_i};
        end
    end

    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    // three pin wiring ignores chip select; hold bit never reaches the link
    assign cs_active = four_pin_mode_i ? ~cs_sync_reg[1] : 1'b1;
    // must match the sequencer's last-edge branch, or an aborted word would still land
    assign word_done = (state_reg == bss_pkg::ST_SHIFT) && sclk_fall && cs_active
                       && module_enable_i && !force_length_error_i
                       && !(group_start_i && multi_buffer_mode_i)
                       && (bit_cnt_reg == LAST_BIT);
    assign suspend_hit = receive_empty_flag_reg[cur_reg]
                         && ((mode_ram[cur_reg] == bss_pkg::MODE_SUSPEND_A)
                         || (mode_ram[cur_reg] == bss_pkg::MODE_SUSPEND_B));

    // ==========================================
    // transmit ram
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            transmit_full_flag_reg <= '0;
        end else begin
            if (state_reg == bss_pkg::ST_FETCH && !suspend_hit)
                transmit_full_flag_reg[cur_reg] <= 1'b0;
            if (tx_write_i) begin
                tx_ram[tx_index_i]   <= tx_data_i;
                mode_ram[tx_index_i] <= buffer_mode_field_i;
                transmit_full_flag_reg[tx_index_i] <= 1'b1;
            end
        end
    end

    // ==========================================
    // sequencer
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg     <= bss_pkg::ST_IDLE;
            cur_reg       <= '0;
            bit_cnt_reg   <= '0;
            shift_out_reg <= bss_pkg::RST_WORD;
            shift_in_reg  <= bss_pkg::RST_WORD;
        end else if (!module_enable_i) begin
            state_reg <= bss_pkg::ST_IDLE;
        end else if (group_start_i && multi_buffer_mode_i) begin
            state_reg <= bss_pkg::ST_FETCH;
            cur_reg   <= group_first_i;
        end else begin
            case (state_reg)
                bss_pkg::ST_IDLE: begin
                    if (!multi_buffer_mode_i && transmit_full_flag_reg[0]) begin
                        cur_reg   <= '0;
                        state_reg <= bss_pkg::ST_FETCH;
                    end
                end
                bss_pkg::ST_FETCH: begin
                    if (!transmit_full_flag_reg[cur_reg]) begin
                        state_reg <= bss_pkg::ST_IDLE;
                    end else if (mode_ram[cur_reg] == bss_pkg::MODE_SKIP
                                 || (mode_ram[cur_reg] == bss_pkg::MODE_DISABLED
                                 && !multi_buffer_mode_i)) begin
                        cur_reg <= cur_reg + 3'h1;
                    end else if (!suspend_hit) begin
                        shift_out_reg <= tx_ram[cur_reg];
                        bit_cnt_reg   <= '0;
                        state_reg     <= bss_pkg::ST_SHIFT;
                    end
                end
                bss_pkg::ST_SHIFT: begin
                    if (force_length_error_i || (!cs_active && bit_cnt_reg != '0)) begin
                        state_reg <= bss_pkg::ST_STOP;
                    end else if (cs_active && sclk_rise) begin
                        shift_in_reg <= {shift_in_reg[bss_pkg::WORD_W-2:0], si_sync_reg[1]};
                    end else if (cs_active && sclk_fall) begin
                        // phase 1: data changes on the falling edge
                        shift_out_reg <= {shift_out_reg[bss_pkg::WORD_W-2:0], 1'b0};
                        bit_cnt_reg   <= bit_cnt_reg + 5'h1;
                        if (bit_cnt_reg == LAST_BIT) begin
                            state_reg <= multi_buffer_mode_i ? bss_pkg::ST_FETCH
                                                             : bss_pkg::ST_IDLE;
                            if (multi_buffer_mode_i)
                                cur_reg <= cur_reg + 3'h1;
                        end
                    end
                end
                // stays stopped until module enable is cleared or a group start arrives in multi buffer mode
                bss_pkg::ST_STOP: state_reg <= bss_pkg::ST_STOP;
                default:          state_reg <= bss_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // receive ram and flags
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            receive_empty_flag_reg <= '0;
            overrun_error_o        <= bss_pkg::RST_FLAG;
            data_length_error_o    <= bss_pkg::RST_FLAG;
            rx_dma_request_o       <= bss_pkg::RST_FLAG;
            rx_data_o              <= bss_pkg::RST_WORD;
        end else begin
            rx_dma_request_o <= word_done && dma_request_enable_i;
            if (rx_read_i) begin
                rx_data_o <= rx_ram[rx_index_i];
                receive_empty_flag_reg[rx_index_i] <= 1'b0;
            end
            if (word_done) begin
                // all sixteen bits were taken on rising edges already
                rx_ram[cur_reg] <= shift_in_reg;
                receive_empty_flag_reg[cur_reg] <= 1'b1;                      // set wins
                if (receive_empty_flag_reg[cur_reg] && !(rx_read_i && rx_index_i == cur_reg))
                    overrun_error_o <= 1'b1;
            end
            if (state_reg == bss_pkg::ST_SHIFT && module_enable_i
                && (force_length_error_i || (!cs_active && bit_cnt_reg != '0)))
                data_length_error_o <= 1'b1;
        end
    end

    assign slave_out_line_o           = shift_out_reg[bss_pkg::WORD_W-1];
    assign slave_out_line_oe_o        = cs_active && state_reg == bss_pkg::ST_SHIFT;
    assign slave_enable_handshake_n_o = ~(four_pin_mode_i && state_reg == bss_pkg::ST_SHIFT);
    assign receive_empty_flag_o       = receive_empty_flag_reg[rx_index_i];
    assign suspended_o = state_reg == bss_pkg::ST_FETCH && suspend_hit;
    assign busy_o      = state_reg != bss_pkg::ST_IDLE;

    // ==========================================
    // assertions
    sequence s_word_end;
        word_done;
    endsequence

    a_dma_needs_word: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(rx_dma_request_o) |-> $past(word_done) && $past(dma_request_enable_i))
        else $error("dma request without a received word");
    a_dma_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !$past(dma_request_enable_i) |-> !rx_dma_request_o)
        else $error("dma request while disabled");
    a_dma_after_word: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_word_end |=> rx_dma_request_o == $past(dma_request_enable_i))
        else $error("dma request missing after word");
    a_enable_idles: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !module_enable_i |=> state_reg == bss_pkg::ST_IDLE)
        else $error("active while module disabled");
    a_error_stops: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(data_length_error_o) |-> state_reg == bss_pkg::ST_STOP)
        else $error("length error did not stop transfer");
    a_stop_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_reg == bss_pkg::ST_STOP && module_enable_i && !group_start_i
        |=> state_reg == bss_pkg::ST_STOP)
        else $error("stopped transfer restarted");
    a_force_error: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_reg == bss_pkg::ST_SHIFT && module_enable_i && force_length_error_i
        |=> data_length_error_o)
        else $error("forced length error not raised");
    a_read_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rx_read_i && !(word_done && rx_index_i == cur_reg)
        |=> !receive_empty_flag_reg[$past(rx_index_i)])
        else $error("empty flag not cleared by read");
    a_suspend_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
        suspended_o && module_enable_i && !group_start_i
        |=> state_reg != bss_pkg::ST_SHIFT)
        else $error("suspended buffer started shifting");
    a_reset_clear: assert property (@(posedge clk_i)
        rstn_i && !$past(rstn_i) |-> !data_length_error_o && !overrun_error_o)
        else $error("error flags not clear after reset");
endmodule

// ==== verilog/bss_pkg.sv ====
// Contract
// - slave shifts correct data at any clock rate; the code needs the serial clock well below the bus clock
// - chip select hold bit has no effect
// - length error aborts transfer and stops
// - loopback control bit 16 forces length error
// - module enable bit 24 gates all transfers
// - receive dma request only after real word
// - dma requests only while request enable set
// - reading a receive buffer clears empty flag
// - modes 6 and 7 suspend on unread data; mode 7 only in multi buffered mode, standard mode skips it as disabled
// - other modes report overrun on unread data
// - higher priority group preempts, fetch restarts
// - each transmit buffer carries a full flag
// - skip or disabled modes bypass the buffer; disabled mode 7 is bypassed only in standard mode
// - standard and multi buffered modes both supported
// - three or four pin slave wiring
package bss_pkg;
    // ==========================================
    // geometry
    localparam int unsigned WORD_W   = 16;
    localparam int unsigned BUF_N    = 8;
    localparam int unsigned IDX_W    = 3;
    localparam int unsigned CNT_W    = 5;
    // ==========================================
    // field positions
    localparam int unsigned MODULE_ENABLE_BIT      = 24;
    localparam int unsigned DMA_REQ_ENABLE_BIT     = 16;
    localparam int unsigned FORCE_LENGTH_ERROR_BIT = 16;
    // ==========================================
    // buffer modes
    localparam logic [2:0] MODE_SKIP      = 3'h0;
    localparam logic [2:0] MODE_DISABLED  = 3'h7;
    localparam logic [2:0] MODE_SUSPEND_A = 3'h6;
    localparam logic [2:0] MODE_SUSPEND_B = 3'h7;
    // ==========================================
    // reset values
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_FLAG   = 1'b0;
    localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_STOP  = 4'b1000
    } bss_state_t;
endpackage

// ==== dv/bss_spi_master.sv ====
`timescale 1ns/1ps
module bss_spi_master (
    output logic      serial_clock_o,
    output logic      chip_select_n_o,
    output logic      slave_in_o,
    input  wire logic slave_out_i
);
    initial begin
        serial_clock_o  = 1'b0;
        chip_select_n_o = 1'b1;
        slave_in_o      = 1'b1;
    end
    // ==========================================
    // frame: clock idles low and stands still between frames
    task automatic xfer(input logic [15:0] tx, input int half, output logic [15:0] rx);
        chip_select_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            slave_in_o = tx[i];
            #(half);
            rx[i] = slave_out_i;
            serial_clock_o = 1'b1;
            #(half);
            serial_clock_o = 1'b0;
        end
        // released line shows the inverse so a stale value cannot pass
        slave_in_o = ~tx[0];
        #(half);
        chip_select_n_o = 1'b1;
    endtask
    task automatic sel(input logic on);
        chip_select_n_o = ~on;
    endtask
endmodule

// ==== dv/buffered_spi_slave_dma_flags_bench.sv ====
`timescale 1ns/1ps
module buffered_spi_slave_dma_flags_bench;
    logic        clk_i = 1'b0, rstn_i = 1'b0;
    logic        serial_clock_i, slave_chip_select_n_i, slave_in_line_i;
    logic        slave_out_line_o, slave_out_line_oe_o, slave_enable_handshake_n_o;
    logic        module_enable_i = 1'b0, dma_request_enable_i = 1'b0;
    logic        force_length_error_i = 1'b0, multi_buffer_mode_i = 1'b0;
    logic        four_pin_mode_i = 1'b1, group_start_i = 1'b0, tx_write_i = 1'b0;
    logic        chip_select_hold_i = 1'b0, rx_read_i = 1'b0;
    logic [2:0]  group_first_i = 3'h0, tx_index_i = 3'h0, rx_index_i = 3'h0;
    logic [2:0]  buffer_mode_field_i = 3'h0;
    logic [15:0] tx_data_i = 16'h0000, rx_data_o, got;
    logic        receive_empty_flag_o, rx_dma_request_o, data_length_error_o;
    logic        overrun_error_o, suspended_o, busy_o;
    int          error_cnt = 0, n_checks = 0, dma_cnt = 0, cyc = 0;

    always #25 clk_i = ~clk_i;

    bss_slave bss_slave_inst (.clk_i, .rstn_i, .serial_clock_i, .slave_chip_select_n_i,
        .slave_in_line_i, .slave_out_line_o, .slave_out_line_oe_o, .slave_enable_handshake_n_o,
        .module_enable_i, .dma_request_enable_i, .force_length_error_i, .multi_buffer_mode_i,
        .four_pin_mode_i, .group_start_i, .group_first_i, .tx_write_i, .tx_index_i,
        .tx_data_i, .buffer_mode_field_i, .chip_select_hold_i, .rx_read_i, .rx_index_i,
        .rx_data_o, .receive_empty_flag_o, .rx_dma_request_o, .data_length_error_o,
        .overrun_error_o, .suspended_o, .busy_o);

    bss_spi_master bss_spi_master_inst (.serial_clock_o(serial_clock_i),
        .chip_select_n_o(slave_chip_select_n_i), .slave_in_o(slave_in_line_i),
        .slave_out_i(slave_out_line_o));

    // ==========================================
    // helpers
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rx_dma_request_o === 1'b1) dma_cnt <= dma_cnt + 1;
        if (cyc == 20000) begin
            $display("CHECK FAILED at %0t: timeout", $time);
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] g, e, input string what);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic ctl(input logic me, de, fe, mb);
        @(posedge clk_i);
        module_enable_i <= me;
        dma_request_enable_i <= de;
        force_length_error_i <= fe;
        multi_buffer_mode_i <= mb;
        tick(3);
    endtask
    task automatic wr_tx(input logic [2:0] i, input logic [15:0] d, input logic [2:0] m,
                         input logic h);
        @(posedge clk_i);
        tx_write_i <= 1'b1;
        tx_index_i <= i;
        tx_data_i <= d;
        buffer_mode_field_i <= m;
        chip_select_hold_i <= h;
        @(posedge clk_i);
        tx_write_i <= 1'b0;
        tick(4);
    endtask
    task automatic rd_rx(input logic [2:0] i, input logic [15:0] e);
        @(posedge clk_i);
        rx_index_i <= i;
        rx_read_i <= 1'b1;
        @(posedge clk_i);
        rx_read_i <= 1'b0;
        @(negedge clk_i);
        chk(rx_data_o, e, "rx word");
        chk(16'(receive_empty_flag_o), 16'h0000, "flag after read");
    endtask
    task automatic grp(input logic [2:0] f);
        @(posedge clk_i);
        group_start_i <= 1'b1;
        group_first_i <= f;
        @(posedge clk_i);
        group_start_i <= 1'b0;
        tick(4);
    endtask
    task automatic xfer(input logic [15:0] d, input int half);
        // start off the sampling edge so pin changes never race the synchronisers
        @(negedge clk_i);
        bss_spi_master_inst.xfer(d, half, got);
        tick(8);
    endtask

    // ==========================================
    // tests
    initial begin
        tick(20);
        rstn_i <= 1'b1;
        tick(2);
        chk(16'({data_length_error_o, overrun_error_o, rx_dma_request_o, busy_o,
                 slave_enable_handshake_n_o}), 16'h0001, "reset state");
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        wr_tx(3'h0, 16'ha53c, 3'h1, 1'b1);
        chk(16'({slave_enable_handshake_n_o, busy_o}), 16'h0001, "four pin waits");
        chk(16'(slave_out_line_oe_o), 16'h0000, "no drive unselected");
        xfer(16'h3c5a, 200);
        chk(got, 16'ha53c, "tx with hold set");
        chk(16'(dma_cnt), 16'h0001, "dma after word");
        chk(16'(receive_empty_flag_o), 16'h0001, "unread flag");
        rd_rx(3'h0, 16'h3c5a);
        wr_tx(3'h0, 16'h0ff1, 3'h1, 1'b0);
        xfer(16'h1234, 600);
        chk(got, 16'h0ff1, "tx slow clock");
        rd_rx(3'h0, 16'h1234);
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        wr_tx(3'h0, 16'h8001, 3'h1, 1'b0);
        xfer(16'h7ffe, 200);
        chk(16'(dma_cnt), 16'h0002, "no dma when disabled");
        rd_rx(3'h0, 16'h7ffe);
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        bss_spi_master_inst.sel(1'b1);
        tick(10);
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        tick(10);
        chk(16'(dma_cnt), 16'h0002, "no dma on idle disable");
        bss_spi_master_inst.sel(1'b0);
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        wr_tx(3'h0, 16'h1111, 3'h1, 1'b0);
        xfer(16'h2222, 200);
        wr_tx(3'h0, 16'h3333, 3'h1, 1'b0);
        xfer(16'h4444, 200);
        chk(16'(overrun_error_o), 16'h0001, "overrun on unread");
        rd_rx(3'h0, 16'h4444);
        ctl(1'b1, 1'b1, 1'b1, 1'b0);
        wr_tx(3'h0, 16'h5555, 3'h1, 1'b0);
        xfer(16'h6666, 200);
        chk(16'(data_length_error_o), 16'h0001, "forced length error");
        chk(16'(dma_cnt), 16'h0004, "aborted word gives no dma");
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        ctl(1'b0, 1'b0, 1'b0, 1'b0);
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        wr_tx(3'h0, 16'h9696, 3'h1, 1'b0);
        xfer(16'h6969, 200);
        chk(got, 16'h9696, "fresh data after re-enable");
        chk(16'(dma_cnt), 16'h0005, "dma after re-enable");
        rd_rx(3'h0, 16'h6969);
        @(posedge clk_i);
        four_pin_mode_i <= 1'b0;
        wr_tx(3'h0, 16'h0f0f, 3'h1, 1'b0);
        chk(16'({slave_out_line_oe_o, slave_enable_handshake_n_o}), 16'h0003, "3 pin");
        xfer(16'hf0f0, 200);
        chk(got, 16'h0f0f, "three pin tx");
        rd_rx(3'h0, 16'hf0f0);
        @(posedge clk_i);
        four_pin_mode_i <= 1'b1;
        ctl(1'b1, 1'b1, 1'b0, 1'b1);
        wr_tx(3'h0, 16'hc001, bss_pkg::MODE_SUSPEND_A, 1'b0);
        grp(3'h0);
        xfer(16'h0c01, 200);
        wr_tx(3'h0, 16'hc002, bss_pkg::MODE_SUSPEND_A, 1'b0);
        grp(3'h0);
        tick(10);
        chk(16'(suspended_o), 16'h0001, "suspend on unread");
        rd_rx(3'h0, 16'h0c01);
        tick(4);
        chk(16'(suspended_o), 16'h0000, "resume after read");
        xfer(16'h0c02, 200);
        chk(got, 16'hc002, "multi mode tx");
        rd_rx(3'h0, 16'h0c02);
        wr_tx(3'h2, 16'hdead, bss_pkg::MODE_SKIP, 1'b0);
        wr_tx(3'h3, 16'hbeef, 3'h1, 1'b0);
        grp(3'h2);
        xfer(16'hf00d, 200);
        chk(got, 16'hbeef, "skip buffer bypassed");
        rd_rx(3'h3, 16'hf00d);
        wr_tx(3'h4, 16'h1357, 3'h1, 1'b0);
        grp(3'h4);
        wr_tx(3'h5, 16'h2468, 3'h1, 1'b0);
        grp(3'h5);
        xfer(16'h0a0a, 200);
        chk(got, 16'h2468, "preempting group sent");
        rd_rx(3'h5, 16'h0a0a);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        tick(3);
        rstn_i <= 1'b1;
        tick(2);
        chk(16'({data_length_error_o, overrun_error_o, busy_o}), 16'h0000, "reset clears");
        tally_and_finish();
    end
endmodule
